// file: hdl/sbf_pkg.sv
// Purpose: Shared constants and types for the serial baud/frame slice
// Assumes: 8-bit register port, one bus clock
// Notes:   Offsets are the register port addresses
package sbf_pkg;

    // ********
    // Widths
    // ********
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DIV_W  = 13;
    localparam int DIVH_W = 5;
    localparam int CHAR_W = 9;
    localparam int SUB_W  = 4;
    localparam int CNT_W  = 4;

    // ********
    // Register map and reset values
    // ********
    localparam logic [ADDR_W-1:0] OFS_BAUD_HI    = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_BAUD_LO    = 8'h41;
    localparam logic [ADDR_W-1:0] OFS_FRAME_CTRL = 8'h42;

    localparam logic [DATA_W-1:0] RST_BAUD_HI    = 8'h00;
    localparam logic [DATA_W-1:0] RST_BAUD_LO    = 8'h04;
    localparam logic [DATA_W-1:0] RST_FRAME_CTRL = 8'h00;
    localparam logic [DATA_W-1:0] RD_NONE        = 8'h00;

    // ********
    // Field positions
    // ********
    localparam int HI_BRK_IE  = 7;
    localparam int HI_EDGE_IE = 6;
    localparam int HI_DIV_MSB = 4;
    localparam int C1_LOOP    = 7;
    localparam int C1_RX_SOURCE_SELECT    = 5;
    localparam int C1_M       = 4;
    localparam int C1_ILT     = 2;
    localparam int C1_PE      = 1;
    localparam int C1_PT      = 0;

    // Bits 6 and 3 belong to fields outside this slice and read as zero
    localparam logic [DATA_W-1:0] C1_WR_MASK = 8'hB7;

    // ********
    // Timing
    // ********
    localparam logic [SUB_W-1:0] OVS_LAST  = 4'hF;
    localparam logic [SUB_W-1:0] OVS_MID   = 4'h7;
    localparam logic [CNT_W-1:0] LEN_8     = 4'h8;
    localparam logic [CNT_W-1:0] LEN_9     = 4'h9;
    localparam logic [CNT_W-1:0] IDLE_8    = 4'hA;
    localparam logic [CNT_W-1:0] IDLE_9    = 4'hB;
    localparam logic [DIV_W-1:0] DIV_ZERO  = 13'h0000;
    localparam logic [DIV_W-1:0] DIV_ONE   = 13'h0001;

    // ********
    // State types
    // ********
    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } sbf_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } sbf_rx_state_t;

endpackage

// file: hdl/sbf_baud_gen.sv
// Purpose: Divide the bus clock by the baud divisor into 16x ticks
// Assumes: Divisor stable or changed between ticks
// Notes:   Counter is held at zero while not running
`timescale 1ns/1ps
`default_nettype none
module sbf_baud_gen
    import sbf_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_run,
    input  wire logic [sbf_pkg::DIV_W-1:0] i_divisor,
    output logic                          o_tick
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!i_run) begin
            cnt_next = DIV_ZERO;
        end else if (cnt_reg >= i_divisor - DIV_ONE) begin
            cnt_next  = DIV_ZERO;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + DIV_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= DIV_ZERO;
            o_tick  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            o_tick  <= tick_next;
        end
    end
endmodule
`default_nettype wire

// file: hdl/sbf_top.sv
// Purpose: Baud, frame and routing configuration of a serial port
// Assumes: Register port and pins synchronous to I_CLK
// Notes:   Registers read one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module sbf_top
    import sbf_pkg::*;
(
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST,
    input  wire logic [sbf_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [sbf_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                       I_WR,
    input  wire logic                       I_RD,
    output logic      [sbf_pkg::DATA_W-1:0] O_RDATA,
    input  wire logic                       I_TX_ON,
    input  wire logic                       I_RX_ON,
    input  wire logic                       I_TX_DIR,
    input  wire logic                       I_BRK_FLAG,
    input  wire logic                       I_EDGE_FLAG,
    output logic                            O_IRQ,
    input  wire logic                       I_RXD,
    input  wire logic                       I_TXD,
    output logic                            O_TXD,
    output logic                            O_TXD_OE,
    input  wire logic [sbf_pkg::CHAR_W-1:0] I_TX_DATA,
    input  wire logic                       I_TX_VALID,
    output logic                            O_TX_READY,
    output logic      [sbf_pkg::CHAR_W-1:0] O_RX_DATA,
    output logic                            O_RX_VALID,
    output logic                            O_PARITY_ERR,
    output logic                            O_FRAME_ERR,
    output logic                            O_IDLE
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [CNT_W-1:0] sbf_char_len(input logic nine);
        return nine ? LEN_9 : LEN_8;
    endfunction

    function automatic logic [CHAR_W-1:0] sbf_add_parity(
        input logic [CHAR_W-1:0] d,
        input logic              nine,
        input logic              pe,
        input logic              odd
    );
        logic [CHAR_W-1:0] r;
        r = d;
        if (pe && nine) begin
            r[8] = (^d[7:0]) ^ odd;
        end else if (pe) begin
            r[7] = (^d[6:0]) ^ odd;
        end
        return r;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [1:0]        irq_en_reg;
    logic [1:0]        irq_en_next;
    logic [DIVH_W-1:0] div_hi_buf_reg;
    logic [DIVH_W-1:0] div_hi_buf_next;
    logic [DIVH_W-1:0] div_hi_reg;
    logic [DIVH_W-1:0] div_hi_next;
    logic [DATA_W-1:0] div_lo_reg;
    logic [DATA_W-1:0] div_lo_next;
    logic [DATA_W-1:0] ctrl1_reg;
    logic [DATA_W-1:0] ctrl1_next;
    logic [DATA_W-1:0] rdata_next;
    logic              started_reg;
    logic              started_next;
    logic              irq_next;
    logic [DIV_W-1:0]  baud_divisor;
    logic              loop_sel;
    logic              rx_source_select_sel;
    logic              nine_bit;
    logic              tick16;

    assign baud_divisor = {div_hi_reg, div_lo_reg};
    assign loop_sel     = ctrl1_reg[C1_LOOP];
    assign rx_source_select_sel     = ctrl1_reg[C1_RX_SOURCE_SELECT];
    assign nine_bit     = ctrl1_reg[C1_M];

    always_comb begin
        irq_en_next     = irq_en_reg;
        div_hi_buf_next = div_hi_buf_reg;
        div_hi_next     = div_hi_reg;
        div_lo_next     = div_lo_reg;
        ctrl1_next      = ctrl1_reg;
        rdata_next      = RD_NONE;
        if (I_WR && I_ADDR == OFS_BAUD_HI) begin
            irq_en_next     = {I_WDATA[HI_BRK_IE], I_WDATA[HI_EDGE_IE]};
            div_hi_buf_next = I_WDATA[HI_DIV_MSB:0];
        end
        if (I_WR && I_ADDR == OFS_BAUD_LO) begin
            div_hi_next = div_hi_buf_reg;
            div_lo_next = I_WDATA;
        end
        if (I_WR && I_ADDR == OFS_FRAME_CTRL) begin
            ctrl1_next = I_WDATA & C1_WR_MASK;
        end
        if (I_RD) begin
            unique case (I_ADDR)
                OFS_BAUD_HI:
                    rdata_next = {irq_en_reg, 1'b0, div_hi_buf_reg};
                OFS_BAUD_LO:    rdata_next = div_lo_reg;
                OFS_FRAME_CTRL: rdata_next = ctrl1_reg;
                default:        rdata_next = RD_NONE;
            endcase
        end
        // Latches on first enable; the non-zero reset divisor must not run
        started_next = started_reg | I_TX_ON | I_RX_ON;
        irq_next = (I_BRK_FLAG & irq_en_reg[1])
                 | (I_EDGE_FLAG & irq_en_reg[0]);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            irq_en_reg     <= {RST_BAUD_HI[HI_BRK_IE], RST_BAUD_HI[HI_EDGE_IE]};
            div_hi_buf_reg <= RST_BAUD_HI[HI_DIV_MSB:0];
            div_hi_reg     <= RST_BAUD_HI[HI_DIV_MSB:0];
            div_lo_reg     <= RST_BAUD_LO;
            ctrl1_reg      <= RST_FRAME_CTRL;
            O_RDATA        <= RD_NONE;
            started_reg    <= 1'b0;
            O_IRQ          <= 1'b0;
        end else begin
            irq_en_reg     <= irq_en_next;
            div_hi_buf_reg <= div_hi_buf_next;
            div_hi_reg     <= div_hi_next;
            div_lo_reg     <= div_lo_next;
            ctrl1_reg      <= ctrl1_next;
            O_RDATA        <= rdata_next;
            started_reg    <= started_next;
            O_IRQ          <= irq_next;
        end
    end

    // ****************************************
    // Baud generator
    // ****************************************
    sbf_baud_gen u_baud (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_run     (started_reg && baud_divisor != DIV_ZERO),
        .i_divisor (baud_divisor),
        .o_tick    (tick16)
    );

    // ****************************************
    // Transmitter
    // ****************************************
    sbf_tx_state_t     tx_state_reg;
    sbf_tx_state_t     tx_state_next;
    logic [CHAR_W-1:0] tx_shift_reg;
    logic [CHAR_W-1:0] tx_shift_next;
    logic [SUB_W-1:0]  tx_sub_reg;
    logic [SUB_W-1:0]  tx_sub_next;
    logic [CNT_W-1:0]  tx_cnt_reg;
    logic [CNT_W-1:0]  tx_cnt_next;
    logic              tx_line_next;
    logic              tx_oe_next;
    logic              tx_bit_end;

    assign tx_bit_end = tick16 && tx_sub_reg == OVS_LAST;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_sub_next   = tick16 ? tx_sub_reg + 4'h1 : tx_sub_reg;
        unique case (tx_state_reg)
            TX_IDLE: begin
                tx_sub_next = 4'h0;
                if (I_TX_ON && I_TX_VALID) begin
                    tx_state_next = TX_START;
                    tx_shift_next = sbf_add_parity(I_TX_DATA, nine_bit,
                        ctrl1_reg[C1_PE], ctrl1_reg[C1_PT]);
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    tx_state_next = TX_DATA;
                    tx_cnt_next   = 4'h0;
                end
            end
            TX_DATA: begin
                if (tx_bit_end) begin
                    tx_shift_next = {1'b1, tx_shift_reg[CHAR_W-1:1]};
                    tx_cnt_next   = tx_cnt_reg + 4'h1;
                    if (tx_cnt_reg == sbf_char_len(nine_bit) - 4'h1) begin
                        tx_state_next = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (tx_bit_end) begin
                    tx_state_next = TX_IDLE;
                end
            end
        endcase
        unique case (tx_state_next)
            TX_START: tx_line_next = 1'b0;
            TX_DATA:  tx_line_next = tx_shift_next[0];
            default:  tx_line_next = 1'b1;
        endcase
        // Single wire: direction input decides who owns the shared line
        tx_oe_next = I_TX_ON && (!(loop_sel && rx_source_select_sel) || I_TX_DIR);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 9'h1FF;
            tx_sub_reg   <= 4'h0;
            tx_cnt_reg   <= 4'h0;
            O_TXD        <= 1'b1;
            O_TXD_OE     <= 1'b0;
            O_TX_READY   <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_sub_reg   <= tx_sub_next;
            tx_cnt_reg   <= tx_cnt_next;
            O_TXD        <= tx_line_next;
            O_TXD_OE     <= tx_oe_next;
            O_TX_READY   <= I_TX_ON && tx_state_next == TX_IDLE;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    sbf_rx_state_t     rx_state_reg;
    sbf_rx_state_t     rx_state_next;
    logic [CHAR_W-1:0] rx_shift_reg;
    logic [CHAR_W-1:0] rx_shift_next;
    logic [SUB_W-1:0]  rx_sub_reg;
    logic [SUB_W-1:0]  rx_sub_next;
    logic [CNT_W-1:0]  rx_cnt_reg;
    logic [CNT_W-1:0]  rx_cnt_next;
    logic [CHAR_W-1:0] rx_data_next;
    logic [CHAR_W-1:0] rx_word;
    logic              rx_prev_reg;
    logic              rx_in;
    logic              rx_valid_next;
    logic              par_err_next;
    logic              frm_err_next;
    logic              rx_mid;
    logic              rx_start_seen;

    always_comb begin
        if (!loop_sel) begin
            rx_in = I_RXD;
        end else if (rx_source_select_sel) begin
            rx_in = I_TXD;
        end else begin
            rx_in = O_TXD;
        end
    end

    assign rx_mid        = tick16 && rx_sub_reg == OVS_MID;
    assign rx_start_seen = I_RX_ON && rx_state_reg == RX_IDLE
                           && rx_prev_reg && !rx_in;
    assign rx_word       = nine_bit ? rx_shift_reg
                                    : {1'b0, rx_shift_reg[CHAR_W-1:1]};

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_data_next  = O_RX_DATA;
        rx_valid_next = 1'b0;
        par_err_next  = O_PARITY_ERR;
        frm_err_next  = O_FRAME_ERR;
        rx_sub_next   = tick16 ? rx_sub_reg + 4'h1 : rx_sub_reg;
        unique case (rx_state_reg)
            RX_IDLE: begin
                rx_sub_next = 4'h0;
                if (rx_start_seen) begin
                    rx_state_next = RX_START;
                end
            end
            RX_START: begin
                if (rx_mid && rx_in) begin
                    rx_state_next = RX_IDLE; // False start
                end else if (tick16 && rx_sub_reg == OVS_LAST) begin
                    rx_state_next = RX_DATA;
                    rx_cnt_next   = 4'h0;
                end
            end
            RX_DATA: begin
                if (rx_mid) begin
                    rx_shift_next = {rx_in, rx_shift_reg[CHAR_W-1:1]};
                end
                if (tick16 && rx_sub_reg == OVS_LAST) begin
                    rx_cnt_next = rx_cnt_reg + 4'h1;
                    if (rx_cnt_reg == sbf_char_len(nine_bit) - 4'h1) begin
                        rx_state_next = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_mid) begin
                    // Leave at mid stop so a back-to-back start edge is seen
                    rx_state_next = RX_IDLE;
                    rx_data_next  = rx_word;
                    rx_valid_next = 1'b1;
                    frm_err_next  = !rx_in;
                    par_err_next  = ctrl1_reg[C1_PE]
                                    && ((^rx_word) ^ ctrl1_reg[C1_PT]);
                end
            end
        endcase
        if (!I_RX_ON) begin
            rx_state_next = RX_IDLE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rx_state_reg <= RX_IDLE;
            rx_shift_reg <= 9'h000;
            rx_sub_reg   <= 4'h0;
            rx_cnt_reg   <= 4'h0;
            rx_prev_reg  <= 1'b1;
            O_RX_DATA    <= 9'h000;
            O_RX_VALID   <= 1'b0;
            O_PARITY_ERR <= 1'b0;
            O_FRAME_ERR  <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_sub_reg   <= rx_sub_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_prev_reg  <= rx_in;
            O_RX_DATA    <= rx_data_next;
            O_RX_VALID   <= rx_valid_next;
            O_PARITY_ERR <= par_err_next;
            O_FRAME_ERR  <= frm_err_next;
        end
    end

    // ****************************************
    // Idle-line detection
    // ****************************************
    logic [SUB_W-1:0] idle_sub_reg;
    logic [SUB_W-1:0] idle_sub_next;
    logic [CNT_W-1:0] idle_cnt_reg;
    logic [CNT_W-1:0] idle_cnt_next;
    logic [CNT_W-1:0] idle_target;
    logic             idle_next;

    assign idle_target = nine_bit ? IDLE_9 : IDLE_8;

    always_comb begin
        idle_sub_next = tick16 ? idle_sub_reg + 4'h1 : idle_sub_reg;
        idle_cnt_next = idle_cnt_reg;
        idle_next     = O_IDLE;
        if (tick16 && idle_sub_reg == OVS_LAST && rx_in
            && idle_cnt_reg != idle_target) begin
            idle_cnt_next = idle_cnt_reg + 4'h1;
        end
        // Stop-bit mode clears the count while a character is in flight
        if (!rx_in || rx_start_seen || !I_RX_ON
            || (ctrl1_reg[C1_ILT] && rx_state_reg != RX_IDLE)) begin
            idle_cnt_next = 4'h0;
        end
        if (rx_start_seen || !I_RX_ON) begin
            idle_sub_next = 4'h0;
            idle_next     = 1'b0;
        end else if (idle_cnt_reg == idle_target) begin
            idle_next = 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            idle_sub_reg <= 4'h0;
            idle_cnt_reg <= 4'h0;
            O_IDLE       <= 1'b0;
        end else begin
            idle_sub_reg <= idle_sub_next;
            idle_cnt_reg <= idle_cnt_next;
            O_IDLE       <= idle_next;
        end
    end

endmodule
`default_nettype wire

// file: sim/sbf_top_asserts.sv
// Purpose: Port-level checks for the serial baud/frame slice
// Assumes: Sees only the ports of sbf_top
// Notes:   Interrupt enables are mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
module sbf_top_chk
    import sbf_pkg::*;
(
    input wire logic                       I_CLK,
    input wire logic                       I_RST,
    input wire logic [sbf_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [sbf_pkg::DATA_W-1:0] I_WDATA,
    input wire logic                       I_WR,
    input wire logic                       I_RD,
    input wire logic [sbf_pkg::DATA_W-1:0] O_RDATA,
    input wire logic                       I_TX_ON,
    input wire logic                       I_RX_ON,
    input wire logic                       I_BRK_FLAG,
    input wire logic                       I_EDGE_FLAG,
    input wire logic                       O_IRQ,
    input wire logic                       O_TXD,
    input wire logic                       I_TX_VALID,
    input wire logic                       O_TX_READY,
    input wire logic                       O_RX_VALID,
    input wire logic                       O_IDLE
);
    // ********
    // Enable mirror and properties
    // ********
    logic [1:0] en_reg;
    logic [1:0] en_next;
    logic       irq_calc;
    always_comb begin
        en_next = en_reg;
        if (I_WR && I_ADDR == OFS_BAUD_HI) begin
            en_next = I_WDATA[HI_BRK_IE:HI_EDGE_IE];
        end
    end
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            en_reg <= 2'h0;
        end else begin
            en_reg <= en_next;
        end
    end
    assign irq_calc = (I_BRK_FLAG & en_reg[1]) | (I_EDGE_FLAG & en_reg[0]);
    default clocking dc @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    a_irq_follow:
    assert property (O_IRQ == $past(irq_calc)) else $error("irq mismatch");
    a_hi_bit5:
    assert property ($past(I_RD) && $past(I_ADDR) == OFS_BAUD_HI
        |-> !O_RDATA[5]) else $error("bit5 set");
    a_rdata_quiet:
    assert property (!$past(I_RD) |-> O_RDATA == RD_NONE)
        else $error("rdata not idle");
    a_ready_on:
    assert property (O_TX_READY |-> $past(I_TX_ON))
        else $error("ready while off");
    a_start_take:
    assert property (I_TX_VALID && I_TX_ON && O_TX_READY
        |=> !O_TXD && !O_TX_READY) else $error("no start after take");
    a_ready_mark:
    assert property (O_TX_READY |-> O_TXD) else $error("line low");
    a_bit_len:
    assert property ($fell(O_TXD) |-> (!O_TXD)[*8])
        else $error("low bit short");
    a_rx_pulse:
    assert property (O_RX_VALID |=> !O_RX_VALID) else $error("rx valid long");
    a_idle_off:
    assert property (O_IDLE && !I_RX_ON |-> ##[1:3] !O_IDLE)
        else $error("idle kept");
    c_take: cover property (I_TX_VALID && O_TX_READY);
    c_rx: cover property (O_RX_VALID);
    c_irq: cover property (O_IRQ);
    c_idle: cover property (O_IDLE);
endmodule
bind sbf_top sbf_top_chk u_chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .I_TX_ON(I_TX_ON), .I_RX_ON(I_RX_ON),
    .I_BRK_FLAG(I_BRK_FLAG), .I_EDGE_FLAG(I_EDGE_FLAG), .O_IRQ(O_IRQ),
    .O_TXD(O_TXD), .I_TX_VALID(I_TX_VALID), .O_TX_READY(O_TX_READY),
    .O_RX_VALID(O_RX_VALID), .O_IDLE(O_IDLE));
`default_nettype wire

// file: sim/sbf_remote_node.sv
// Purpose: Remote node driving frames onto the line
// Assumes: Line has a pull-up, so it idles high between frames
// Notes:   Bit period is given in bus clocks by the caller
`timescale 1ns/1ps
`default_nettype none
module sbf_remote_node (
    input  wire logic i_clk,
    output logic      o_line
);
    initial begin
        o_line = 1'b1;
    end
    task automatic send(input logic [8:0] c, input int n, input int bc);
        int i;
        @(posedge i_clk);
        o_line <= 1'b0;
        repeat (bc) @(posedge i_clk);
        for (i = 0; i < n; i++) begin
            o_line <= c[i];
            repeat (bc) @(posedge i_clk);
        end
        o_line <= 1'b1;
        repeat (2 * bc) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: sim/serial_baud_frame_config_test.sv
// Purpose: Self-checking bench for the serial baud/frame slice
// Assumes: Small divisors keep frames short
// Notes:   Jam holds the receive pin low
`timescale 1ns/1ps
`default_nettype none
module serial_baud_frame_config_test;
    import sbf_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       tx_on = 1'b0;
    logic       rx_on = 1'b0;
    logic       dir = 1'b0;
    logic       brk = 1'b0;
    logic       edg = 1'b0;
    logic       jam = 1'b0;
    logic       tx_valid = 1'b0;
    logic [8:0] tx_data = 9'h000;
    logic [7:0] rdata;
    logic [8:0] rx_data;
    logic       irq, txd, oe, ready, rx_valid, perr, ferr, idle, line;
    int         errors = 0;
    int         comparisons = 0;
    int         rx_cnt = 0;
    int         k;
    logic [7:0] cfgs [6] = '{8'h80, 8'h82, 8'h83, 8'h90, 8'h92, 8'h93};
    initial begin
        forever #50 clk = ~clk;
    end
    sbf_remote_node node (.i_clk(clk), .o_line(line));
    sbf_top DUT (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TX_ON(tx_on),
        .I_RX_ON(rx_on), .I_TX_DIR(dir), .I_BRK_FLAG(brk),
        .I_EDGE_FLAG(edg), .O_IRQ(irq), .I_RXD(jam ? 1'b0 : line),
        .I_TXD(oe ? txd : line), .O_TXD(txd), .O_TXD_OE(oe),
        .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid), .O_TX_READY(ready),
        .O_RX_DATA(rx_data), .O_RX_VALID(rx_valid), .O_PARITY_ERR(perr),
        .O_FRAME_ERR(ferr), .O_IDLE(idle));
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
        end
    end
    // ********
    // Access and comparison tasks
    // ********
    task automatic chk(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk("rdata", rdata, exp);
    endtask
    // Bounded wait on ready (sel 1) or the transmit line (sel 0)
    task automatic wait_on(input logic sel, input logic v, input int lim);
        int n = 0;
        while ((sel ? ready : txd) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if ((sel ? ready : txd) !== v) begin
            errors++;
            close_out();
        end
    endtask
    function automatic logic [8:0] fr(input logic [8:0] d,
                                      input logic [7:0] cfg);
        logic [8:0] c;
        c = cfg[C1_M] ? d : {1'b0, d[7:0]};
        if (cfg[C1_PE] && cfg[C1_M]) c[8] = ^c[7:0] ^ cfg[C1_PT];
        if (cfg[C1_PE] && !cfg[C1_M]) c[7] = ^c[6:0] ^ cfg[C1_PT];
        return c;
    endfunction
    task automatic tx_frame(input logic [8:0] d, input logic [7:0] cfg,
                            input int bc);
        logic [10:0] got;
        logic [8:0]  c;
        int          i;
        c = fr(d, cfg);
        wait_on(1'b1, 1'b1, 4 * bc);
        tx_data  <= d;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        wait_on(1'b0, 1'b0, 4 * bc);
        repeat (bc / 2) @(posedge clk);
        for (i = 0; i < 11; i++) begin
            got[i] = txd;
            repeat (bc) @(posedge clk);
        end
        chk("tx frame", got, cfg[C1_M] ? {1'b1, c, 1'b0} :
            {2'b11, c[7:0], 1'b0});
    endtask
    task automatic rx_expect(input int k0, input logic [8:0] c,
                             input logic pe);
        chk("rx count", 11'(rx_cnt - k0), 11'h001);
        chk("rx data", rx_data, c);
        chk("perr", perr, pe);
        chk("ferr", ferr, 1'b0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(8'h40, 8'h00);
        rd_reg(8'h41, 8'h04);
        rd_reg(8'h42, 8'h00);
        wr_reg(8'h40, 8'hFF);
        rd_reg(8'h40, 8'hDF);
        wr_reg(8'h43, 8'h5A);
        rd_reg(8'h43, 8'h00);
        wr_reg(8'h42, 8'hFF);
        rd_reg(8'h42, 8'hB7);
        brk <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        wr_reg(8'h40, 8'h40);
        @(posedge clk);
        chk("irq", irq, 1'b0);
        brk <= 1'b0;
        edg <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        edg <= 1'b0;
        wr_reg(8'h40, 8'h00);
        wr_reg(8'h41, 8'h02);
        wr_reg(8'h40, 8'h01);
        tx_on <= 1'b1;
        jam   <= 1'b1;
        wr_reg(8'h42, 8'h80);
        rx_on <= 1'b1;
        k = rx_cnt;
        tx_frame(9'h0A5, 8'h80, 32);
        rx_expect(k, 9'h0A5, 1'b0);
        wr_reg(8'h40, 8'h00);
        wr_reg(8'h41, 8'h01);
        foreach (cfgs[j]) begin
            wr_reg(8'h42, cfgs[j]);
            k = rx_cnt;
            tx_frame(9'h1A5, cfgs[j], 16);
            rx_expect(k, fr(9'h1A5, cfgs[j]), 1'b0);
        end
        jam <= 1'b0;
        wr_reg(8'h42, 8'h20);
        k = rx_cnt;
        fork
            tx_frame(9'h03C, 8'h20, 16);
            node.send(9'h0C3, 8, 16);
        join
        rx_expect(k, 9'h0C3, 1'b0);
        wr_reg(8'h42, 8'h03);
        k = rx_cnt;
        node.send(fr(9'h055, 8'h03) ^ 9'h080, 8, 16);
        rx_expect(k, fr(9'h055, 8'h03) ^ 9'h080, 1'b1);
        dir <= 1'b1;
        wr_reg(8'h42, 8'hA0);
        jam <= 1'b1;
        @(posedge clk);
        chk("oe", oe, 1'b1);
        dir <= 1'b0;
        repeat (2) @(posedge clk);
        chk("oe", oe, 1'b0);
        k = rx_cnt;
        node.send(9'h096, 8, 16);
        rx_expect(k, 9'h096, 1'b0);
        repeat (200) @(posedge clk);
        chk("idle", idle, 1'b1);
        rx_on <= 1'b0;
        repeat (4) @(posedge clk);
        chk("idle", idle, 1'b0);
        wr_reg(8'h41, 8'h00);
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        repeat (300) @(posedge clk);
        chk("ready", ready, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
